/* design/deser_ctrl_consts.vh */
/*
 * Offsets, field positions and reset values of the datapath,
 * timing, colour balance and audio control registers.
 * Assumes inclusion by bare name from the design files.
 */
// Overview of operation
// RL1: override bit set blocks remote datapath loads; clear lets remote load it.
// RL2: video-disabled bit resets to one; control channel and pins keep working.
// RL3: link-mode bit tells single or dual link; used in auto-detect receive.
// RL4: alternate audio puts word clock on pin 1 and data on pin 0.
// RL5: 28-bit video takes hsync, vsync and enable from the video word.
// RL6: surround bit one enables multichannel audio output, zero disables it; the code also holds it off while the audio-off bit is set.
// RL7: timing-mode zero uses data-enable only; one uses separate syncs.
// RL8: three bits set hsync, vsync, enable polarity; one means active low.
// RL9: page field steers balance access: config, red, green, blue tables.
// RL10: balance correction applied only while its enable bit is one.
// RL11: audio FIFO overrun shown in a read-only status bit.
// RL12: audio FIFO underrun shown in a separate read-only status bit.
// RL13: writing one to error-reset clears overrun and underrun indications.
// RL14: edge-select one strobes data on rising edge, zero falling; resets zero.
// RL15: lock-mode zero asserts receive lock only while video-disabled is zero.
// RL16: input-mode 00 auto, 01 dual, 10 primary single, 11 secondary single.
// RL17: overrun and underrun stay set until error-reset; reads do not clear.
`ifndef DESER_CTRL_CONSTS_VH
`define DESER_CTRL_CONSTS_VH

`define ADDR_DATAPATH 8'h28
`define ADDR_TIMING 8'h29
`define ADDR_BALANCE 8'h2A
`define ADDR_AUDIO 8'h2B

`define RST_DATAPATH 8'h20
`define RST_TIMING 8'h00
`define RST_BALANCE 8'h00
`define RST_AUDIO 8'h00

`define DP_BLOCK_REMOTE 7
`define DP_VIDEO_OFF 5
`define DP_DUAL_LINK 4
`define DP_ALT_AUDIO 3
`define DP_AUDIO_OFF 2
`define DP_SYNC_IN_WORD 1
`define DP_SURROUND 0
`define DP_USED_MASK 8'hBF

`define TM_SYNC_MODE 7
`define TM_HS_LOW 6
`define TM_VS_LOW 5
`define TM_DE_LOW 4

`define WB_PAGE_HI 7
`define WB_PAGE_LO 6
`define WB_ENABLE 5
`define WB_RELOAD 4
`define WB_USED_MASK 8'hF0

`define AU_OVERRUN 3
`define AU_UNDERRUN 2
`define AU_ERR_CLR 1
`define AU_RISING 0

`define MODE_AUTO 2'h0
`define MODE_DUAL 2'h1
`define MODE_PRIMARY 2'h2
`define MODE_SECONDARY 2'h3

`endif

/* design/audio_word_fifo.v */
/*
 * Synchronous FIFO for audio sample words, valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module audio_word_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_sys,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data_q
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg [AW:0] fill_q;
  reg in_ready_q;
  reg out_valid_q;
  wire [AW:0] fill_d;
  wire push;
  wire pop;
  wire load;

  // fill counts the output register too, so no more than DEPTH words are held
  // ready is registered from the next fill so the upstream sees a flop
  assign in_ready = in_ready_q;
  assign push = in_valid & in_ready_q;
  assign fill_d = fill_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_valid = out_valid_q;
  assign load = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);
  assign pop = out_valid_q & out_ready;

  always @(posedge clk_sys) begin
    if (push)
      mem[wr_q] <= in_data;
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      fill_q <= {(AW+1){1'b0}};
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end else begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (load) begin
        out_data_q <= mem[rd_q];
        rd_q <= rd_q + 1'b1;
        out_valid_q <= 1'b1;
      end else if (pop) begin
        out_valid_q <= 1'b0;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      fill_q <= fill_d;
      in_ready_q <= (fill_d != DEPTH[AW:0]);
    end
  end
endmodule // audio_word_fifo
`default_nettype wire

/* design/deser_datapath_ctrl.v */
/*
 * Datapath, display timing, colour balance and audio control registers
 * of the deserializer, with the audio word FIFO and the effects of each
 * control bit on the video, sync, audio and pin paths.
 * Assumes a local register port (address, write and read strobes) and a
 * remote load strobe from the forward-channel decoder, all on clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
`include "deser_ctrl_consts.vh"
module deser_datapath_ctrl #(
  parameter AUD_W = 32,
  parameter AUD_DEPTH = 8,
  parameter AUD_AW = 3,
  parameter PIX_W = 24
) (
  input wire clk_sys,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  input wire remote_load,
  input wire [7:0] remote_data,
  input wire [1:0] receive_input_mode,
  input wire lock_mode,
  input wire link_up,
  output reg rx_lock_q,
  output reg ctrl_chan_en_q,
  output reg dual_rx_q,
  output reg secondary_rx_q,
  input wire [PIX_W-1:0] pix_in,
  input wire [PIX_W-1:0] pix_balanced,
  input wire pix_hs,
  input wire pix_vs,
  input wire pix_de,
  input wire word_hs,
  input wire word_vs,
  input wire word_de,
  output reg [PIX_W-1:0] pix_out_q,
  output reg hsync_out_q,
  output reg vsync_out_q,
  output reg de_out_q,
  output reg video_valid_q,
  output reg [1:0] balance_page_q,
  output reg table_refresh_enable_q,
  output reg dither_one_enable_q,
  output reg dither_two_enable_q,
  output reg high_dither_one_off_q,
  output reg high_dither_two_off_q,
  input wire aud_in_valid,
  output wire aud_in_ready,
  input wire [AUD_W-1:0] aud_in_data,
  input wire aud_take,
  output reg [AUD_W-1:0] aud_word_q,
  output reg aud_word_valid_q,
  input wire aud_wclk,
  input wire aud_sdata,
  input wire gpio0_func,
  input wire gpio1_func,
  output reg aud_wclk_out_q,
  output reg aud_sdata_out_q,
  output reg gpio0_out_q,
  output reg gpio1_out_q,
  output reg surround_en_q,
  output reg strobe_rising_q
);
  reg [7:0] datapath_q;
  reg [7:0] timing_q;
  reg [7:0] balance_q;
  localparam [7:0] au_rst_val = `RST_AUDIO;
  reg [1:0] audio_ctl_q;
  reg overrun_q;
  reg underrun_q;
  reg [7:0] rd_d;
  reg hs_raw;
  reg vs_raw;
  reg de_raw;
  wire wr_dp;
  wire wr_tm;
  wire wr_wb;
  wire wr_au;
  wire err_clr;
  wire fifo_out_valid;
  wire [AUD_W-1:0] fifo_out_data;
  wire fifo_pop;
  wire overrun_evt;
  wire underrun_evt;
  wire video_off;
  wire alt_audio;

  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // polarity: a set level-select bit means the pin is active low
  function level_out;
    input active;
    input active_low;
    begin
      level_out = active ^ active_low;
    end
  endfunction

  assign wr_dp = reg_wr & hit(reg_addr, `ADDR_DATAPATH);
  assign wr_tm = reg_wr & hit(reg_addr, `ADDR_TIMING);
  assign wr_wb = reg_wr & hit(reg_addr, `ADDR_BALANCE);
  assign wr_au = reg_wr & hit(reg_addr, `ADDR_AUDIO);
  assign err_clr = wr_au & reg_wdata[`AU_ERR_CLR]; // [RL13]
  assign video_off = datapath_q[`DP_VIDEO_OFF];
  assign alt_audio = datapath_q[`DP_ALT_AUDIO];

  // local write wins over a remote load in the same cycle
  always @(posedge clk_sys) begin
    if (srst) begin
      datapath_q <= `RST_DATAPATH; // [RL2]
    end else if (wr_dp) begin
      datapath_q <= reg_wdata & `DP_USED_MASK;
    end else if (remote_load & ~datapath_q[`DP_BLOCK_REMOTE]) begin // [RL1]
      datapath_q <= {1'b0, remote_data[6:0]} & `DP_USED_MASK;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      timing_q <= `RST_TIMING;
      balance_q <= `RST_BALANCE;
      audio_ctl_q <= au_rst_val[1:0]; // [RL14]
    end else begin
      if (wr_tm)
        timing_q <= reg_wdata;
      if (wr_wb)
        balance_q <= reg_wdata & `WB_USED_MASK;
      if (wr_au)
        audio_ctl_q <= reg_wdata[1:0];
    end
  end

  // audio samples queue here; the audio serializer takes one per word slot
  audio_word_fifo #(
    .WIDTH(AUD_W),
    .DEPTH(AUD_DEPTH),
    .AW(AUD_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(aud_in_valid),
    .in_ready(aud_in_ready),
    .in_data(aud_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(aud_take),
    .out_data_q(fifo_out_data)
  );

  assign fifo_pop = aud_take & fifo_out_valid;
  assign overrun_evt = aud_in_valid & ~aud_in_ready;
  assign underrun_evt = aud_take & ~fifo_out_valid;

  // sticky until the error reset; a fresh event in the clear cycle survives
  always @(posedge clk_sys) begin
    if (srst) begin
      overrun_q <= 1'b0;
      underrun_q <= 1'b0;
    end else begin
      if (overrun_evt)
        overrun_q <= 1'b1; // [RL11] [RL17]
      else if (err_clr)
        overrun_q <= 1'b0; // [RL13]
      if (underrun_evt)
        underrun_q <= 1'b1; // [RL12] [RL17]
      else if (err_clr)
        underrun_q <= 1'b0; // [RL13]
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      aud_word_q <= {AUD_W{1'b0}};
      aud_word_valid_q <= 1'b0;
    end else begin
      aud_word_valid_q <= fifo_pop & ~datapath_q[`DP_AUDIO_OFF];
      if (fifo_pop)
        aud_word_q <= fifo_out_data;
    end
  end

  // reads have no side effect on the status bits
  always @* begin
    rd_d = 8'h00;
    case (reg_addr)
      `ADDR_DATAPATH: rd_d = datapath_q;
      `ADDR_TIMING: rd_d = timing_q;
      `ADDR_BALANCE: rd_d = balance_q;
      `ADDR_AUDIO: rd_d = {4'h0, overrun_q, underrun_q, audio_ctl_q}; // [RL11] [RL12]
      default: rd_d = 8'h00;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
      reg_rdata_q <= rd_d;
  end

  // link status and receive mode
  always @(posedge clk_sys) begin
    if (srst) begin
      rx_lock_q <= 1'b0;
      ctrl_chan_en_q <= 1'b0;
      dual_rx_q <= 1'b0;
      secondary_rx_q <= 1'b0;
    end else begin
      rx_lock_q <= link_up & (lock_mode | ~video_off); // [RL15]
      ctrl_chan_en_q <= link_up; // [RL2]
      case (receive_input_mode)
        `MODE_AUTO: dual_rx_q <= datapath_q[`DP_DUAL_LINK]; // [RL3] [RL16]
        `MODE_DUAL: dual_rx_q <= 1'b1; // [RL16]
        default: dual_rx_q <= 1'b0; // [RL16]
      endcase
      secondary_rx_q <= (receive_input_mode == `MODE_SECONDARY); // [RL16]
    end
  end

  // sync source: carried in the video word or on separate inputs
  always @* begin
    if (datapath_q[`DP_SYNC_IN_WORD]) begin // [RL5]
      hs_raw = word_hs;
      vs_raw = word_vs;
      de_raw = word_de;
    end else begin
      hs_raw = pix_hs;
      vs_raw = pix_vs;
      de_raw = pix_de;
    end
  end

  // in enable-only timing the sync pins rest at their inactive level
  always @(posedge clk_sys) begin
    if (srst) begin
      pix_out_q <= {PIX_W{1'b0}};
      hsync_out_q <= 1'b0;
      vsync_out_q <= 1'b0;
      de_out_q <= 1'b0;
      video_valid_q <= 1'b0;
    end else begin
      video_valid_q <= link_up & ~video_off;
      if (balance_q[`WB_ENABLE]) // [RL10]
        pix_out_q <= pix_balanced;
      else
        pix_out_q <= pix_in;
      hsync_out_q <= level_out(hs_raw & timing_q[`TM_SYNC_MODE], timing_q[`TM_HS_LOW]); // [RL7] [RL8]
      vsync_out_q <= level_out(vs_raw & timing_q[`TM_SYNC_MODE], timing_q[`TM_VS_LOW]); // [RL7] [RL8]
      de_out_q <= level_out(de_raw & ~video_off, timing_q[`TM_DE_LOW]); // [RL8]
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      balance_page_q <= 2'h0;
      table_refresh_enable_q <= 1'b0;
      dither_one_enable_q <= 1'b0;
      dither_two_enable_q <= 1'b0;
      high_dither_one_off_q <= 1'b0;
      high_dither_two_off_q <= 1'b0;
    end else begin
      balance_page_q <= balance_q[`WB_PAGE_HI:`WB_PAGE_LO]; // [RL9]
      table_refresh_enable_q <= balance_q[`WB_RELOAD];
      dither_two_enable_q <= timing_q[3];
      dither_one_enable_q <= timing_q[2];
      high_dither_two_off_q <= timing_q[1];
      high_dither_one_off_q <= timing_q[0];
    end
  end

  // audio pins; general-purpose pins keep working while video is off
  always @(posedge clk_sys) begin
    if (srst) begin
      aud_wclk_out_q <= 1'b0;
      aud_sdata_out_q <= 1'b0;
      gpio0_out_q <= 1'b0;
      gpio1_out_q <= 1'b0;
      surround_en_q <= 1'b0;
      strobe_rising_q <= 1'b0;
    end else begin
      surround_en_q <= datapath_q[`DP_SURROUND] & ~datapath_q[`DP_AUDIO_OFF]; // [RL6]
      strobe_rising_q <= audio_ctl_q[`AU_RISING]; // [RL14]
      if (alt_audio) begin // [RL4]
        gpio1_out_q <= aud_wclk;
        gpio0_out_q <= aud_sdata;
        aud_wclk_out_q <= 1'b0;
        aud_sdata_out_q <= 1'b0;
      end else begin
        gpio1_out_q <= gpio1_func; // [RL2]
        gpio0_out_q <= gpio0_func; // [RL2]
        aud_wclk_out_q <= aud_wclk & ~datapath_q[`DP_AUDIO_OFF];
        aud_sdata_out_q <= aud_sdata & ~datapath_q[`DP_AUDIO_OFF];
      end
    end
  end
endmodule // deser_datapath_ctrl
`default_nettype wire

/* test/deser_ctrl_chk.sv */
/* assertion checker for deser_datapath_ctrl, bound to it at the foot.
   sees only the block's ports; control bits are shadowed from port traffic. */
`timescale 1ns/10ps
`default_nettype none
`include "deser_ctrl_consts.vh"
module deser_ctrl_chk #(
  parameter PIX_W = 24
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic remote_load,
  input wire logic [7:0] remote_data,
  input wire logic [1:0] receive_input_mode,
  input wire logic lock_mode,
  input wire logic link_up,
  input wire logic rx_lock_q,
  input wire logic ctrl_chan_en_q,
  input wire logic dual_rx_q,
  input wire logic [PIX_W-1:0] pix_in,
  input wire logic [PIX_W-1:0] pix_balanced,
  input wire logic [PIX_W-1:0] pix_out_q,
  input wire logic pix_hs,
  input wire logic word_hs,
  input wire logic hsync_out_q,
  input wire logic pix_vs,
  input wire logic word_vs,
  input wire logic vsync_out_q,
  input wire logic pix_de,
  input wire logic word_de,
  input wire logic de_out_q,
  input wire logic video_valid_q,
  input wire logic aud_sdata,
  input wire logic gpio0_func,
  input wire logic gpio0_out_q,
  input wire logic aud_wclk_out_q,
  input wire logic aud_wclk,
  input wire logic gpio1_func,
  input wire logic gpio1_out_q,
  input wire logic surround_en_q,
  input wire logic strobe_rising_q
);
  logic [7:0] dp_q, tm_q;
  logic bal_q, rise_q;
  always @(posedge clk_sys) begin
    if (srst) begin
      dp_q <= `RST_DATAPATH;
      tm_q <= `RST_TIMING;
      bal_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `ADDR_DATAPATH) dp_q <= reg_wdata & `DP_USED_MASK;
      else if (remote_load && !dp_q[7]) dp_q <= {1'b0, remote_data[6:0]} & `DP_USED_MASK;
      if (reg_wr && reg_addr == `ADDR_TIMING) tm_q <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_BALANCE) bal_q <= reg_wdata[5];
      if (reg_wr && reg_addr == `ADDR_AUDIO) rise_q <= reg_wdata[0];
    end
  end
  // $past takes plain signals only, so expectations are formed here first
  wire logic hs_exp = tm_q[7] ? ((dp_q[1] ? word_hs : pix_hs) ^ tm_q[6]) : tm_q[6];
  wire logic [PIX_W-1:0] pix_exp = bal_q ? pix_balanced : pix_in;
  wire logic wclk_exp = dp_q[3] ? aud_wclk : gpio1_func;
  wire logic surr_exp = dp_q[0] & ~dp_q[2];
  wire logic vs_exp = tm_q[7] ? ((dp_q[1] ? word_vs : pix_vs) ^ tm_q[5]) : tm_q[5];
  wire logic de_exp = ((dp_q[1] ? word_de : pix_de) & ~dp_q[5]) ^ tm_q[4];
  wire logic valid_exp = link_up & ~dp_q[5];
  wire logic sdat_exp = dp_q[3] ? aud_sdata : gpio0_func;
  wire logic wpin_exp = ~dp_q[3] & aud_wclk & ~dp_q[2];
  wire logic lock_exp = link_up & (lock_mode | ~dp_q[5]);
  wire logic dual_exp = receive_input_mode == `MODE_DUAL || (receive_input_mode == `MODE_AUTO && dp_q[4]);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  chk_dp_readback: assert property (
    reg_rd && reg_addr == `ADDR_DATAPATH |=> reg_rdata_q == $past(dp_q)) else $error("datapath readback wrong");
  chk_tm_readback: assert property (
    reg_rd && reg_addr == `ADDR_TIMING |=> reg_rdata_q == $past(tm_q)) else $error("timing readback wrong");
  chk_hs_level: assert property (
    !$past(srst) |-> hsync_out_q == $past(hs_exp)) else $error("hsync level wrong");
  chk_pix_path: assert property (
    !$past(srst) |-> pix_out_q == $past(pix_exp)) else $error("pixel path wrong");
  chk_alt_wclk: assert property (
    !$past(srst) |-> gpio1_out_q == $past(wclk_exp)) else $error("pin 1 source wrong");
  chk_surround_out: assert property (
    !$past(srst) |-> surround_en_q == $past(surr_exp)) else $error("surround enable wrong");
  chk_edge_select: assert property (
    !$past(srst) |-> strobe_rising_q == $past(rise_q)) else $error("strobe edge wrong");
  chk_lock_video: assert property (
    !$past(srst) |-> rx_lock_q == $past(lock_exp)) else $error("receive lock wrong");
  chk_ctrl_chan: assert property (
    link_up [*2] |-> ctrl_chan_en_q) else $error("control channel off while linked");
  chk_dual_rx: assert property (
    !$past(srst) |-> dual_rx_q == $past(dual_exp)) else $error("dual reception wrong");
  chk_vs_level: assert property (
    !$past(srst) |-> vsync_out_q == $past(vs_exp)) else $error("vsync level wrong");
  chk_de_level: assert property (
    !$past(srst) |-> de_out_q == $past(de_exp)) else $error("enable level wrong");
  chk_video_valid: assert property (
    !$past(srst) |-> video_valid_q == $past(valid_exp)) else $error("video valid wrong");
  chk_alt_data: assert property (
    !$past(srst) |-> gpio0_out_q == $past(sdat_exp)) else $error("pin 0 source wrong");
  chk_wclk_pin: assert property (
    !$past(srst) |-> aud_wclk_out_q == $past(wpin_exp)) else $error("word clock pin wrong");
  cover property (remote_load && dp_q[7]);
  cover property (dp_q[3] && !lock_mode);
  cover property (rx_lock_q && tm_q[7] && bal_q);
endmodule // deser_ctrl_chk
bind deser_datapath_ctrl deser_ctrl_chk #(.PIX_W(PIX_W)) chk_i (.*);
`default_nettype wire

/* test/remote_ser_model.sv */
/* remote serializer model: loads the datapath register over the forward channel.
   assumes clk_sys is the device clock; a load is a one-cycle pulse. */
`timescale 1ns/10ps
`default_nettype none
module remote_ser_model (
  input wire logic clk_sys,
  output logic remote_load,
  output logic [7:0] remote_data
);
  initial begin
    remote_load = 1'b0;
    remote_data = 8'hA5;
  end
  // data is inverted after the pulse so nothing can lean on a stale value
  task automatic send(input logic [7:0] d, input int gap);
    repeat (gap + 1) @(posedge clk_sys);
    #1;
    remote_load = 1'b1;
    remote_data = d;
    @(posedge clk_sys);
    #1;
    remote_load = 1'b0;
    remote_data = ~d;
  endtask
endmodule // remote_ser_model
`default_nettype wire

/* test/tb_top.sv */
/* self-checking bench for deser_datapath_ctrl with the remote serializer model.
   assumes the design sources, checker and model are compiled before it. */
`timescale 1ns/10ps
`default_nettype none
`include "deser_ctrl_consts.vh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic srst, reg_wr, reg_rd, remote_load, lock_mode, link_up, pix_hs, pix_vs, pix_de, word_hs, word_vs, word_de;
  logic aud_in_valid, aud_in_ready, aud_take, aud_word_valid_q, aud_wclk, aud_sdata, gpio0_func, gpio1_func;
  logic rx_lock_q, ctrl_chan_en_q, dual_rx_q, secondary_rx_q, hsync_out_q, vsync_out_q, de_out_q, video_valid_q;
  logic table_refresh_enable_q, dither_one_enable_q, dither_two_enable_q, high_dither_one_off_q, high_dither_two_off_q;
  logic aud_wclk_out_q, aud_sdata_out_q, gpio0_out_q, gpio1_out_q, surround_en_q, strobe_rising_q;
  logic [1:0] receive_input_mode, balance_page_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, remote_data;
  logic [23:0] pix_in, pix_balanced, pix_out_q;
  logic [31:0] aud_in_data, aud_word_q;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int i;
  // address, value written, value read back
  logic [23:0] rows [12] = '{24'h28FFBF, 24'h280000, 24'h29A5A5, 24'h298080, 24'h29F0F0, 24'h2AFFF0,
    24'h2A2020, 24'h2BF303, 24'h2B0000, 24'h2CFF00, 24'h275500, 24'h280B0B};
  deser_datapath_ctrl uut (.*);
  remote_ser_model partner (.clk_sys(clk_sys), .remote_load(remote_load), .remote_data(remote_data));
  always #10 clk_sys = ~clk_sys;
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] ex);
    step(1);
    reg_rd = 1'b1;
    reg_addr = a;
    step(1);
    reg_rd = 1'b0;
    `CHK("reg_rdata_q", ex, reg_rdata_q)
  endtask
  // sync, pixel and pin inputs keep moving so the checker sees every path
  initial forever begin
    {word_de, word_vs, word_hs, pix_de, pix_vs, pix_hs, aud_wclk, aud_sdata, gpio0_func, gpio1_func} = cyc[9:0] ^ cyc[12:3];
    pix_in = {cyc[11:0], 12'h5A3};
    pix_balanced = ~pix_in;
    step(1);
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report;
    end
  end
  initial begin
    srst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, lock_mode, aud_in_valid, aud_in_data, aud_take} = '0;
    link_up = 1'b1;
    receive_input_mode = `MODE_AUTO;
    step(12);
    srst = 1'b0;
    for (i = 0; i < 4; i++) rdc(8'h28 + 8'(i), i == 0 ? 8'h20 : 8'h00);
    for (i = 0; i < 12; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      step(4);
      rdc(rows[i][23:16], rows[i][7:0]);
    end
    for (i = 0; i < 4; i++) begin
      wr(`ADDR_BALANCE, {2'(i), 6'h00});
      step(1);
      `CHK("balance_page_q", 2'(i), balance_page_q)
    end
    wr(`ADDR_TIMING, 8'h5A);
    wr(`ADDR_BALANCE, 8'h30);
    step(1);
    `CHK("sync_idle", 2'b10, {hsync_out_q, vsync_out_q})
    `CHK("dither_bits", 4'hA, {dither_two_enable_q, dither_one_enable_q, high_dither_two_off_q, high_dither_one_off_q})
    `CHK("table_refresh_enable_q", 1'b1, table_refresh_enable_q)
    wr(`ADDR_DATAPATH, 8'h00);
    partner.send(8'h12, 0);
    rdc(`ADDR_DATAPATH, 8'h12);
    partner.send(8'hFF, 3);
    rdc(`ADDR_DATAPATH, 8'h3F);
    wr(`ADDR_DATAPATH, 8'h80);
    partner.send(8'h05, 0);
    rdc(`ADDR_DATAPATH, 8'h80);
    step(2);
    `CHK("rx_lock_q", 1'b1, rx_lock_q)
    wr(`ADDR_DATAPATH, 8'hA0);
    step(2);
    `CHK("rx_lock_q", 1'b0, rx_lock_q)
    `CHK("ctrl_chan_en_q", 1'b1, ctrl_chan_en_q)
    lock_mode = 1'b1;
    step(2);
    `CHK("rx_lock_q", 1'b1, rx_lock_q)
    `CHK("de_out_q", 1'b1, de_out_q)
    `CHK("video_valid_q", 1'b0, video_valid_q)
    link_up = 1'b0;
    step(2);
    `CHK("rx_lock_q", 1'b0, rx_lock_q)
    `CHK("ctrl_chan_en_q", 1'b0, ctrl_chan_en_q)
    link_up = 1'b1;
    wr(`ADDR_DATAPATH, 8'h90);
    for (i = 0; i < 4; i++) begin
      receive_input_mode = 2'(i);
      step(2);
      `CHK("dual_rx_q", i < 2, dual_rx_q)
      `CHK("secondary_rx_q", i == 3, secondary_rx_q)
    end
    aud_in_valid = 1'b1;
    for (i = 0; i < 10; i++) begin
      aud_in_data = 32'(i);
      step(1);
    end
    aud_in_valid = 1'b0;
    `CHK("aud_in_ready", 1'b0, aud_in_ready)
    rdc(`ADDR_AUDIO, 8'h08);
    rdc(`ADDR_AUDIO, 8'h08);
    for (i = 0; i < 9; i++) begin
      aud_take = 1'b1;
      step(1);
      aud_take = 1'b0;
      `CHK("aud_word_valid_q", i < 8, aud_word_valid_q)
      if (i < 8) `CHK("aud_word_q", 32'(i), aud_word_q)
      step(2);
    end
    rdc(`ADDR_AUDIO, 8'h0C);
    wr(`ADDR_AUDIO, 8'h02);
    rdc(`ADDR_AUDIO, 8'h02);
    srst = 1'b1;
    step(2);
    srst = 1'b0;
    rdc(`ADDR_DATAPATH, 8'h20);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
